// ===== core/scb_ctrl.sv
// Switched-cap cell control registers, phase steering and bus gating
// ============================================================
// Notes on behaviour
// - feedback bit picks 16 or 32 units
// - A field gives 0 to 31 units
// - swap bit interchanges internal phase one/two
// - bus connects only in late phase two unless swap or hold disable set
// - swap set connects for whole phase two
// - hold disable connects for whole phase two
// - comparator capture and update edges follow swap
// - comparator bus changes only at update or when its enable bit is written
// - sample order picks input or reference phase
// - select top bit picks C source
// - top bit forces A and C shared
// - codes 101 to 111 are reserved
// - second register low bits are B size
// - first registers at 80h 88h 94h 9Ch
// - column bus also gated by drive enable
// - drive enable clear floats column bus
// - undriven comparator bus reads low
//
// Register access over APB was chosen for this implementation.
`default_nettype none
module scb_ctrl
    import scb_pkg::*;
#(
    parameter int PH_CNT_W = 12
)
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          phase_one,
    input  wire logic                          phase_two,
    input  wire logic [NUM_CELLS-1:0]          comparator_in,
    output logic      [NUM_CELLS*FEEDBACK_CAP_SIZE_W-1:0]   feedback_cap_size,
    output logic      [NUM_CELLS*CAP_W-1:0]    a_cap_units,
    output logic      [NUM_CELLS*CAP_W-1:0]    b_cap_units,
    output logic      [NUM_CELLS-1:0]          int_phase_one,
    output logic      [NUM_CELLS-1:0]          int_phase_two,
    output logic      [NUM_CELLS-1:0]          a_sample_input,
    output logic      [NUM_CELLS-1:0]          a_sample_ref,
    output logic      [NUM_CELLS*SEL_W-1:0]    a_source_sel,
    output logic      [NUM_CELLS-1:0]          c_source_top,
    output logic      [NUM_CELLS-1:0]          ac_select_reserved,
    output logic      [NUM_CELLS-1:0]          column_bus_drive_oe,
    output logic      [NUM_CELLS-1:0]          comparator_bus_o,
    output logic      [NUM_CELLS-1:0]          comparator_bus_oe
);

    // ============================================================
    // Register storage
    logic [7:0] ctl_a_r [NUM_CELLS];
    logic [7:0] ctl_b_r [NUM_CELLS];
    logic [7:0] ctl_c_r [NUM_CELLS];
    logic [7:0] global_r;
    logic       hold_disable;

    assign hold_disable = global_r[G_HOLD_DIS_BIT];

    // ============================================================
    // APB decode
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] cell_a_ofs [NUM_CELLS];
    logic              access;
    logic              hit;
    logic [31:0]       rdata;
    logic [NUM_CELLS-1:0] sel_a;
    logic [NUM_CELLS-1:0] sel_b;
    logic [NUM_CELLS-1:0] sel_c;
    logic              sel_g;
    logic              sel_s;
    logic [31:0]       status;

    assign addr   = paddr[ADDR_W-1:0];
    assign access = psel & penable;
    assign cell_a_ofs[0] = OFS_CELL0_CTL_A;
    assign cell_a_ofs[1] = OFS_CELL1_CTL_A;
    assign cell_a_ofs[2] = OFS_CELL2_CTL_A;
    assign cell_a_ofs[3] = OFS_CELL3_CTL_A;

    always_comb
    begin
        sel_g = (paddr[31:ADDR_W] == '0) && (addr == OFS_GLOBAL);
        sel_s = (paddr[31:ADDR_W] == '0) && (addr == OFS_STATUS);
        for (int i = 0; i < NUM_CELLS; i++)
        begin
            sel_a[i] = (paddr[31:ADDR_W] == '0) && (addr == cell_a_ofs[i]);
            sel_b[i] = (paddr[31:ADDR_W] == '0) && (addr ==
                       ADDR_W'(OFS_CTL_B_BASE + OFS_STRIDE * i));
            sel_c[i] = (paddr[31:ADDR_W] == '0) && (addr ==
                       ADDR_W'(OFS_CTL_C_BASE + OFS_STRIDE * i));
        end
        hit = (|sel_a) | (|sel_b) | (|sel_c) | sel_g | sel_s;
    end

    always_comb
    begin
        rdata = '0;
        for (int i = 0; i < NUM_CELLS; i++)
        begin
            if (sel_a[i])
                rdata[7:0] = ctl_a_r[i];
            if (sel_b[i])
                rdata[7:0] = ctl_b_r[i];
            if (sel_c[i])
                rdata[7:0] = ctl_c_r[i];
        end
        if (sel_g)
            rdata[7:0] = global_r;
        if (sel_s)
            rdata = status;
    end

    // Zero wait states; unmapped gives an error and zero data
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata  = (access & ~pwrite) ? rdata : '0;

    // ============================================================
    // Register writes
    logic wr_en;

    assign wr_en = access & pwrite & pstrb[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CELLS; i++)
            begin
                ctl_a_r[i] <= CTL_RESET;
                ctl_b_r[i] <= CTL_RESET;
                ctl_c_r[i] <= CTL_RESET;
            end
            global_r <= CTL_RESET;
        end
        else if (wr_en)
        begin
            for (int i = 0; i < NUM_CELLS; i++)
            begin
                if (sel_a[i])
                    ctl_a_r[i] <= pwdata[7:0];
                if (sel_b[i])
                    ctl_b_r[i] <= pwdata[7:0];
                if (sel_c[i])
                    ctl_c_r[i] <= pwdata[7:0];
            end
            if (sel_g)
                global_r <= pwdata[7:0];
        end
    end

    // ============================================================
    // Phase and comparator synchronisers
    logic       p1_m, p1_s, p1_d;
    logic       p2_m, p2_s, p2_d;
    logic [NUM_CELLS-1:0] cmp_m, cmp_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p1_m  <= 1'b0;
            p1_s  <= 1'b0;
            p1_d  <= 1'b0;
            p2_m  <= 1'b0;
            p2_s  <= 1'b0;
            p2_d  <= 1'b0;
            cmp_m <= '0;
            cmp_s <= '0;
        end
        else
        begin
            p1_m  <= phase_one;
            p1_s  <= p1_m;
            p1_d  <= p1_s;
            p2_m  <= phase_two;
            p2_s  <= p2_m;
            p2_d  <= p2_s;
            cmp_m <= comparator_in;
            cmp_s <= cmp_m;
        end
    end

    logic p1_rise, p1_fall, p2_rise, p2_fall;

    assign p1_rise = p1_s & ~p1_d;
    assign p1_fall = ~p1_s & p1_d;
    assign p2_rise = p2_s & ~p2_d;
    assign p2_fall = ~p2_s & p2_d;

    // ============================================================
    // Late half of external phase two
    // Length of the last high period sets the half point; the very
    // first phase two after reset has no history and connects all but its first cycle.
    logic [PH_CNT_W-1:0] p2_cnt_r;
    logic [PH_CNT_W-1:0] p2_len_r;
    logic                p2_late;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p2_cnt_r <= '0;
            p2_len_r <= '0;
        end
        else if (p2_rise)
            p2_cnt_r <= '0;
        else if (p2_s && p2_cnt_r != '1)
            p2_cnt_r <= p2_cnt_r + 1'b1;
        else if (p2_fall)
            p2_len_r <= p2_cnt_r;
    end

    assign p2_late = p2_s && !p2_rise && (p2_cnt_r >= (p2_len_r >> 1));

    // ============================================================
    // Per-cell decode, bus gating and comparator latch
    logic [NUM_CELLS-1:0] cap_r;
    logic [NUM_CELLS-1:0] comparator_bus_r;

    for (genvar g = 0; g < NUM_CELLS; g++)
    begin : g_cell
        logic swap;
        logic ip1;
        logic ip2;
        logic connect;
        logic [SEL_W-1:0] sel;

        assign swap = ctl_a_r[g][A_SWAP_BIT];
        assign sel  = ctl_b_r[g][B_SEL_TOP:B_SEL_LSB];
        assign ip1  = swap ? p2_s : p1_s;
        assign ip2  = swap ? p1_s : p2_s;

        assign connect = ctl_c_r[g][C_COLBUS_BIT] &
                         ((swap | hold_disable) ? ip2 : p2_late);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cap_r[g] <= 1'b0;
            else if (swap ? p1_fall : p2_fall)
                cap_r[g] <= cmp_s[g];
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                comparator_bus_r[g] <= 1'b0;
            else if (swap ? p2_rise : p1_rise)
                comparator_bus_r[g] <= cap_r[g];
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                feedback_cap_size[g*FEEDBACK_CAP_SIZE_W +: FEEDBACK_CAP_SIZE_W] <= FEEDBACK_CAP_SIZE_SMALL;
                a_cap_units[g*CAP_W +: CAP_W]         <= '0;
                b_cap_units[g*CAP_W +: CAP_W]         <= '0;
                int_phase_one[g]                      <= 1'b0;
                int_phase_two[g]                      <= 1'b0;
                a_sample_input[g]                     <= 1'b0;
                a_sample_ref[g]                       <= 1'b0;
                a_source_sel[g*SEL_W +: SEL_W]        <= '0;
                c_source_top[g]                       <= 1'b0;
                ac_select_reserved[g]                 <= 1'b0;
                column_bus_drive_oe[g]                <= 1'b0;
                comparator_bus_o[g]                   <= 1'b0;
                comparator_bus_oe[g]                  <= 1'b0;
            end
            else
            begin
                feedback_cap_size[g*FEEDBACK_CAP_SIZE_W +: FEEDBACK_CAP_SIZE_W] <=
                    ctl_a_r[g][A_FEEDBACK_CAP_SIZE_BIT] ? FEEDBACK_CAP_SIZE_LARGE : FEEDBACK_CAP_SIZE_SMALL;
                a_cap_units[g*CAP_W +: CAP_W] <=
                    ctl_a_r[g][A_CAP_LSB +: CAP_W];
                b_cap_units[g*CAP_W +: CAP_W] <=
                    ctl_b_r[g][B_CAP_LSB +: CAP_W];
                int_phase_one[g] <= ip1;
                int_phase_two[g] <= ip2;
                a_sample_input[g] <= ctl_a_r[g][A_ORDER_BIT] ? ip2 : ip1;
                a_sample_ref[g]   <= ctl_a_r[g][A_ORDER_BIT] ? ip1 : ip2;
                a_source_sel[g*SEL_W +: SEL_W] <=
                    sel[SEL_W-1] ? SEL_SHARED : sel;
                c_source_top[g] <= sel[SEL_W-1];
                ac_select_reserved[g] <= (sel > SEL_SHARED);
                column_bus_drive_oe[g] <= connect;
                comparator_bus_o[g]  <= ctl_c_r[g][C_CMPBUS_BIT] & comparator_bus_r[g];
                comparator_bus_oe[g] <= ctl_c_r[g][C_CMPBUS_BIT];
            end
        end
    end

    // ============================================================
    // Status word
    always_comb
    begin
        status        = '0;
        status[3:0]   = comparator_bus_o;
        status[7:4]   = column_bus_drive_oe;
        status[8]     = p1_s;
        status[9]     = p2_s;
        status[10]    = hold_disable;
        status[15:12] = ac_select_reserved;
    end

endmodule : scb_ctrl
`default_nettype wire

// ===== core/scb_pkg.sv
// Constants shared by the switched-cap cell control bank
`default_nettype none
package scb_pkg;
    // ============================================================
    // Geometry
    localparam int NUM_CELLS = 4;
    localparam int ADDR_W    = 8;
    localparam int CAP_W     = 5;
    localparam int FEEDBACK_CAP_SIZE_W    = 6;
    localparam int SEL_W     = 3;

    // ============================================================
    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CELL0_CTL_A = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_CELL1_CTL_A = 8'h88;
    localparam logic [ADDR_W-1:0] OFS_CELL2_CTL_A = 8'h94;
    localparam logic [ADDR_W-1:0] OFS_CELL3_CTL_A = 8'h9c;
    localparam logic [ADDR_W-1:0] OFS_CTL_B_BASE  = 8'ha0;
    localparam logic [ADDR_W-1:0] OFS_CTL_C_BASE  = 8'hb0;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL      = 8'hc0;
    localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'hc4;
    localparam logic [ADDR_W-1:0] OFS_STRIDE      = 8'h04;
    localparam logic [7:0]        CTL_RESET       = 8'h00;

    // ============================================================
    // Control A fields
    localparam int A_FEEDBACK_CAP_SIZE_BIT  = 7;
    localparam int A_SWAP_BIT  = 6;
    localparam int A_ORDER_BIT = 5;
    localparam int A_CAP_LSB   = 0;
    // Control B fields
    localparam int B_SEL_LSB   = 5;
    localparam int B_SEL_TOP   = 7;
    localparam int B_CAP_LSB   = 0;
    // Control C fields
    localparam int C_COLBUS_BIT = 7;
    localparam int C_CMPBUS_BIT = 6;
    // Global fields
    localparam int G_HOLD_DIS_BIT = 6;

    // ============================================================
    // Decode values
    localparam logic [FEEDBACK_CAP_SIZE_W-1:0] FEEDBACK_CAP_SIZE_SMALL  = 6'h10;
    localparam logic [FEEDBACK_CAP_SIZE_W-1:0] FEEDBACK_CAP_SIZE_LARGE  = 6'h20;
    localparam logic [SEL_W-1:0]  SEL_SHARED  = 3'h4;
endpackage : scb_pkg
`default_nettype wire

// ===== verif/scb_ctrl_checker.sv
// Port-level assertions for the switched-cap control bank
`default_nettype none
module scb_ctrl_checker
    import scb_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        phase_one,
    input wire logic        phase_two,
    input wire logic [23:0] feedback_cap_size,
    input wire logic [19:0] a_cap_units,
    input wire logic [3:0]  int_phase_one,
    input wire logic [3:0]  int_phase_two,
    input wire logic [11:0] a_source_sel,
    input wire logic [3:0]  c_source_top,
    input wire logic [3:0]  ac_select_reserved,
    input wire logic [3:0]  column_bus_drive_oe,
    input wire logic [3:0]  comparator_bus_o,
    input wire logic [3:0]  comparator_bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] live_r;
    logic [3:0] quiet_r;
    // ============================================================
    // Helper counters
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            live_r <= 4'h0;
        else if (live_r != 4'hf)
            live_r <= live_r + 4'h1;
    // Comparator may only move shortly after an update edge or a bus access
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            quiet_r <= 4'h0;
        else if ($rose(phase_one) || $rose(phase_two) || psel)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    // ============================================================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence wr0_s;
        psel && penable && pwrite && paddr[7:0] == OFS_CELL0_CTL_A;
    endsequence
    property a_cap_units_p;
        wr0_s |-> ##2 a_cap_units[4:0] == $past(pwdata[4:0], 2);
    endproperty
    a_cap_units_follow_a: assert property (a_cap_units_p)
        else $error("a cap size not taken from write");
    feedback_cap_size_large_a: assert property (wr0_s ##0 pwdata[7] |->
        ##[1:3] feedback_cap_size[5:0] == FEEDBACK_CAP_SIZE_LARGE)
        else $error("feedback size not large");
    feedback_cap_size_small_a: assert property (wr0_s ##0 !pwdata[7] |->
        ##[1:3] feedback_cap_size[5:0] == FEEDBACK_CAP_SIZE_SMALL)
        else $error("feedback size not small");
    unmapped_err_a: assert property (psel && penable &&
        paddr[7:0] < 8'h80 |-> pslverr)
        else $error("low address not refused");
    phase_steer_a: assert property (live_r == 4'hf |->
        (int_phase_one[0] == $past(phase_one, 3) &&
         int_phase_two[0] == $past(phase_two, 3)) ||
        (int_phase_one[0] == $past(phase_two, 3) &&
         int_phase_two[0] == $past(phase_one, 3)))
        else $error("internal phases not steered");
    oe_phase_a: assert property (
        (column_bus_drive_oe & ~int_phase_two) == 4'h0)
        else $error("column bus driven outside phase two");
    shared_sel_a: assert property (c_source_top[0] |->
        a_source_sel[2:0] == SEL_SHARED)
        else $error("top select bit not forcing shared");
    reserved_top_a: assert property (
        ac_select_reserved[0] |-> c_source_top[0])
        else $error("reserved code without top bit");
    cmp_quiet_a: assert property (
        $changed(comparator_bus_o) |-> quiet_r <= 4'd6)
        else $error("comparator bus moved between updates");
    cmp_off_low_a: assert property (
        (comparator_bus_o & ~comparator_bus_oe) == 4'h0)
        else $error("undriven comparator bus not low");
endmodule : scb_ctrl_checker

bind scb_ctrl scb_ctrl_checker scb_ctrl_checker_inst (.*);
`default_nettype wire

// ===== verif/scb_analog_model.sv
// Far side: two-phase clock source and comparators
`default_nettype none
module scb_analog_model #(
    parameter int HI = 16
)
(
    input  wire logic pclk,
    input  wire logic run,
    input  wire logic cmp,
    output logic      phase_one,
    output logic      phase_two,
    output logic [3:0] comparator_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int k = 0;
    initial
    begin
        phase_one = 1'b0;
        phase_two = 1'b0;
        comparator_in = 4'h0;
    end
    // Two idle cycles keep the phases from overlapping
    always @(posedge pclk)
    begin
        k <= (k == 2 * HI + 3 || !run) ? 0 : k + 1;
        phase_one <= run && k < HI;
        phase_two <= run && k >= HI + 2 && k < 2 * HI + 2;
        comparator_in <= {4{cmp}};
    end
endmodule : scb_analog_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the switched-cap control bank
`default_nettype none
module tb
    import scb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HI = 16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        phase_one, phase_two, run, cmp, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  pstrb, comparator_in, column_bus_drive_oe;
    logic [3:0]  c_source_top, ac_select_reserved, comparator_bus_o;
    logic [23:0] feedback_cap_size;
    logic [19:0] a_cap_units, b_cap_units;
    logic [11:0] a_source_sel;
    logic [3:0]  int_phase_one, int_phase_two, a_sample_input, a_sample_ref;
    int          n_fail = 0;
    int          tests_run = 0;
    int          n;
    int          m;
    logic [7:0]  ofs [4] = '{OFS_CELL0_CTL_A, OFS_CELL1_CTL_A,
                             OFS_CELL2_CTL_A, OFS_CELL3_CTL_A};

    scb_ctrl scb_ctrl_inst (.*, .comparator_bus_oe());
    scb_analog_model #(.HI(HI)) scb_analog_model_inst (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // ============================================================
    // Bus master and helpers
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cnt;
        n = 0;
        m = 0;
        // Two periods let the last write settle before counting one
        repeat (2 * (2 * HI + 4)) @(posedge pclk);
        repeat (2 * HI + 4)
        begin
            @(posedge pclk);
            n += int'(column_bus_drive_oe[0]);
            m += int'(a_sample_input[0] & int_phase_one[0]);
            m += int'(a_sample_ref[0] & int_phase_two[0]);
        end
    endtask : cnt
    // ============================================================
    // Scenarios
    task automatic t_regs;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, ofs[i], 8'h00);
            chk(rd, 32'h0);
            apb(1'b1, ofs[i], 8'h9f - 8'(i));
            apb(1'b1, OFS_CTL_B_BASE + 8'(4 * i), 8'h10 + 8'(i));
            apb(1'b0, ofs[i], 8'h00);
            chk(rd, 32'h9f - 32'(i));
            repeat (3) @(posedge pclk);
            chk(32'(feedback_cap_size[6*i +: 6]), 32'h20);
            chk(32'(a_cap_units[5*i +: 5]), 32'd31 - 32'(i));
            chk(32'(b_cap_units[5*i +: 5]), 32'h10 + 32'(i));
            apb(1'b1, ofs[i], 8'h00);
            repeat (3) @(posedge pclk);
            chk(32'(feedback_cap_size[6*i +: 6]), 32'h10);
            chk(32'(a_cap_units[5*i +: 5]), 32'h0);
        end
        apb(1'b0, 8'h84, 8'h00);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 8'h7c, 8'hff);
        chk({31'h0, er}, 32'h1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_select;
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, OFS_CTL_B_BASE, {3'(c), 5'h0});
            repeat (3) @(posedge pclk);
            chk(32'(c_source_top[0]), 32'(c / 4));
            chk(32'(a_source_sel[2:0]), c / 4 ? 32'h4 : 32'(c));
            chk(32'(ac_select_reserved[0]), 32'(c > 4));
        end
        $display("test select done");
    endtask : t_select
    task automatic t_bus;
        run <= 1'b1;
        cnt;
        chk(32'(n), 32'h0);
        chk(32'(m), 32'(2 * HI));
        apb(1'b1, OFS_CTL_C_BASE, 8'hc0);
        cnt;
        chk(32'(n >= HI / 2 - 2 && n <= HI / 2 + 2), 32'h1);
        apb(1'b1, OFS_GLOBAL, 8'h40);
        cnt;
        chk(32'(n), 32'(HI));
        apb(1'b1, OFS_GLOBAL, 8'h00);
        apb(1'b1, OFS_CELL0_CTL_A, 8'h60);
        cnt;
        chk(32'(n), 32'(HI));
        chk(32'(m), 32'h0);
        cmp <= 1'b1;
        cnt;
        chk(32'(comparator_bus_o[0]), 32'h1);
        apb(1'b1, OFS_CELL0_CTL_A, 8'h00);
        cmp <= 1'b0;
        cnt;
        chk(32'(comparator_bus_o[0]), 32'h0);
        cmp <= 1'b1;
        apb(1'b1, OFS_CTL_C_BASE, 8'h80);
        cnt;
        chk(32'(comparator_bus_o[0]), 32'h0);
        $display("test bus done");
    endtask : t_bus
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // ============================================================
    // Clock, reset, sequence and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, run, cmp} = 6'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_select;
        t_bus;
        print_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        print_verdict;
    end
endmodule : tb
`default_nettype wire
